// ---- hw/ocm_mode_logic.sv ----
`timescale 1ns/100ps
`include "ocm_defs.svh"
module ocm_mode_logic
  import ocm_pkg::*;
#(
  parameter int CTL_W = `OCM_CTL_W,
  parameter int CMP_W = `OCM_CMP_W,
  parameter bit FAULT_CH = 1'b1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // control
  input  wire logic [CTL_W-1:0] compare_channel_control,
  input  wire logic [CMP_W-1:0] primary_compare_value,
  // compare engine
  input  wire logic             cmp_set,
  input  wire logic             cmp_clear,
  input  wire logic             cmp_toggle,
  // pins
  input  wire logic             fault_input_a,
  input  wire logic             port_level,
  output logic                  compare_output_pin,
  output logic                  pin_owned,
  output logic                  fault_latched,
  output logic                  irq_pulse
);
  ocm_sel_if sel ();
  logic [2:0] mode_q;
  logic       pin_q;
  logic       own_q;
  logic       flt_q;
  logic       irq_q;
  logic       f_s1_q;
  logic       f_s2_q;
  logic       f_s3_q;
  logic       entry;

  assign sel.mode = compare_channel_control[`OCM_CTL_MODE_LSB +: 3];

  ocm_mode_decode u_dec (
    .sel (sel)
  );

  assign entry = (sel.mode != mode_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= `OCM_MODE_OFF;
    end else begin
      mode_q <= sel.mode;
    end
  end

  // fault input synchroniser and edge history
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      f_s1_q <= 1'b1;
      f_s2_q <= 1'b1;
      f_s3_q <= 1'b1;
    end else begin
      f_s1_q <= fault_input_a;
      f_s2_q <= f_s1_q;
      f_s3_q <= f_s2_q;
    end
  end

  // pin ownership
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      own_q <= 1'b0;
    end else begin
      own_q <= sel.enabled;
    end
  end

  // fault latch, held until mode leaves fault pwm
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flt_q <= 1'b0;
    end else if (!sel.fault_watch) begin
      flt_q <= 1'b0;
    end else if (f_s3_q && !f_s2_q) begin
      flt_q <= 1'b1;
    end
  end

  // output pin level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_q <= 1'b0;
    end else if (!sel.enabled) begin
      pin_q <= port_level;
    end else if (entry) begin
      unique case (sel.init)
        ocm_init_low:   pin_q <= 1'b0;
        ocm_init_high:  pin_q <= 1'b1;
        ocm_init_keep:  pin_q <= pin_q;
        ocm_init_value: pin_q <= |primary_compare_value;
      endcase
    end else if (sel.fault_watch && (flt_q || (f_s3_q && !f_s2_q))) begin
      pin_q <= 1'b0;
    end else if (cmp_toggle) begin
      pin_q <= ~pin_q;
    end else if (cmp_set) begin
      pin_q <= 1'b1;
    end else if (cmp_clear) begin
      pin_q <= 1'b0;
    end
  end

  // interrupt on the selected edge, compared against last pin level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else if (entry || !own_q) begin
      irq_q <= 1'b0;
    end else begin
      unique case (sel.irq_src)
        ocm_irq_none:  irq_q <= 1'b0;
        ocm_irq_rise:  irq_q <= pin_q && !compare_output_pin;
        ocm_irq_fall:  irq_q <= !pin_q && compare_output_pin;
        ocm_irq_both:  irq_q <= pin_q != compare_output_pin;
        ocm_irq_fault: irq_q <= FAULT_CH && f_s3_q && !f_s2_q;
        default:       irq_q <= 1'b0;
      endcase
    end
  end

  // delayed copy of pin gives edge reference
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      compare_output_pin <= 1'b0;
      pin_owned          <= 1'b0;
      fault_latched      <= 1'b0;
      irq_pulse          <= 1'b0;
    end else begin
      compare_output_pin <= pin_q;
      pin_owned          <= own_q;
      fault_latched      <= flt_q;
      irq_pulse          <= irq_q;
    end
  end
endmodule : ocm_mode_logic

// ---- pkg/ocm_defs.svh ----
`ifndef OCM_DEFS_SVH
`define OCM_DEFS_SVH
// mode codes of compare_mode_select
`define OCM_MODE_W        3
`define OCM_MODE_OFF      3'h0
`define OCM_MODE_LOSHOT   3'h1
`define OCM_MODE_HISHOT   3'h2
`define OCM_MODE_TOGGLE   3'h3
`define OCM_MODE_DLYSHOT  3'h4
`define OCM_MODE_CONT     3'h5
`define OCM_MODE_PWM      3'h6
`define OCM_MODE_PWMF     3'h7
// field position of the mode in compare_channel_control
`define OCM_CTL_MODE_LSB  0
`define OCM_CTL_W         16
`define OCM_CMP_W         16
`define OCM_CTL_RESET     16'h0000
`endif

// ---- pkg/ocm_pkg.sv ----
package ocm_pkg;
  typedef enum logic [1:0] {
    ocm_init_low,
    ocm_init_high,
    ocm_init_keep,
    ocm_init_value
  } ocm_init_t;
  typedef enum logic [2:0] {
    ocm_irq_none,
    ocm_irq_rise,
    ocm_irq_fall,
    ocm_irq_both,
    ocm_irq_fault
  } ocm_irq_src_t;
endpackage : ocm_pkg

// ---- pkg/ocm_sel_if.sv ----
`timescale 1ns/100ps
interface ocm_sel_if;
  import ocm_pkg::*;
  logic [2:0]   mode;
  ocm_init_t    init;
  ocm_irq_src_t irq_src;
  logic         enabled;
  logic         fault_watch;
  modport dec (input mode, output init, irq_src, enabled, fault_watch);
  modport use_side (output mode, input init, irq_src, enabled, fault_watch);
endinterface : ocm_sel_if

// ---- hw/ocm_mode_decode.sv ----
`timescale 1ns/100ps
`include "ocm_defs.svh"
module ocm_mode_decode
  import ocm_pkg::*;
(
  ocm_sel_if.dec sel
);
  always_comb begin
    sel.init        = ocm_init_low;
    sel.irq_src     = ocm_irq_none;
    sel.enabled     = 1'b1;
    sel.fault_watch = 1'b0;
    unique case (sel.mode)
      `OCM_MODE_OFF: begin
        sel.enabled = 1'b0;
      end
      `OCM_MODE_LOSHOT: begin
        sel.irq_src = ocm_irq_rise;
      end
      `OCM_MODE_HISHOT: begin
        sel.init    = ocm_init_high;
        sel.irq_src = ocm_irq_fall;
      end
      `OCM_MODE_TOGGLE: begin
        sel.init    = ocm_init_keep;
        sel.irq_src = ocm_irq_both;
      end
      `OCM_MODE_DLYSHOT,
      `OCM_MODE_CONT: begin
        sel.irq_src = ocm_irq_fall;
      end
      `OCM_MODE_PWM: begin
        sel.init = ocm_init_value;
      end
      `OCM_MODE_PWMF: begin
        sel.init        = ocm_init_value;
        sel.irq_src     = ocm_irq_fault;
        sel.fault_watch = 1'b1;
      end
    endcase
  end
endmodule : ocm_mode_decode

// ---- verification/ocm_mode_logic_checker.sv ----
`timescale 1ns/100ps
module ocm_mode_logic_checker (
  // watched ports
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] compare_channel_control,
  input wire logic [15:0] primary_compare_value,
  input wire logic        fault_input_a,
  input wire logic        compare_output_pin,
  input wire logic        pin_owned,
  input wire logic        irq_pulse
);
  wire [2:0] m = compare_channel_control[2:0];
  wire p = compare_output_pin;
  wire i = irq_pulse;
  wire f = fault_input_a;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_OFF: assert property ((m == 3'h0)[*4] |-> !i && !pin_owned)
    else $error("off mode active");
  AST_TOG_KEEP: assert property ($changed(m) && m == 3'h3 |-> $stable(p)[*3])
    else $error("toggle entry moved pin");
  AST_TOG_IRQ: assert property (m == 3'h3 && $changed(p) |-> ##[1:3] i)
    else $error("toggle edge no irq");
  AST_PWM_SET: assert property ($changed(m) && m[2:1] == 2'h3 |->
    ##[1:3] p == (primary_compare_value != 16'h0))
    else $error("pwm start level");
  AST_PWM_QUIET: assert property ((m == 3'h6)[*4] |-> !i)
    else $error("pwm irq");
  AST_FLT_LOW: assert property (m == 3'h7 && $fell(f) |-> ##[2:6] !p)
    else $error("fault pin high");
  AST_FLT_IRQ: assert property (m == 3'h7 && $fell(f) |-> ##[2:6] i)
    else $error("fault no irq");
  AST_ONE_SHOT: assert property (m == 3'h1 && $rose(p) |-> ##[1:3] i)
    else $error("rise no irq");
endmodule : ocm_mode_logic_checker
bind ocm_mode_logic ocm_mode_logic_checker ocm_chk (.clk, .rst_b,
  .compare_channel_control, .primary_compare_value, .fault_input_a,
  .compare_output_pin, .pin_owned, .irq_pulse);

// ---- verification/ocm_pin_load.sv ----
`timescale 1ns/100ps
module ocm_pin_load (
  // pin and edge tally
  input  wire logic clk,
  input  wire logic pin,
  output int        edges = 0
);
  logic last_q = 1'b0;
  always_ff @(posedge clk) last_q <= pin;
  always_ff @(posedge clk) if (pin != last_q) edges <= edges + 1;
endmodule : ocm_pin_load

// ---- verification/ocm_mode_logic_tb.sv ----
`timescale 1ns/100ps
module ocm_mode_logic_tb;
  logic clk = 0, rst_b = 0, fa = 1, pl = 1, tg = 0, pin, own, flt, irq;
  logic [15:0] ctl = 16'hFFF8, val = 16'h0000;
  int errors = 0, compares = 0, cyc = 0, edges;
  localparam logic [2:0] CD [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
  ocm_mode_logic dut (.clk, .rst_b, .compare_channel_control(ctl),
    .primary_compare_value(val), .cmp_set(1'b0), .cmp_clear(1'b0),
    .cmp_toggle(tg), .fault_input_a(fa), .port_level(pl),
    .compare_output_pin(pin), .pin_owned(own), .fault_latched(flt),
    .irq_pulse(irq));
  ocm_pin_load load (.clk, .pin, .edges);
  initial forever #10 clk = ~clk;
  task print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task ck(input logic [2:0] g, e);
    compares++;
    errors += int'(g !== e);
    if (g !== e) $display("mismatch %0t exp %h got %h", $time, e, g);
  endtask : ck
  task sm(input logic [2:0] m, input logic [15:0] v);
    @(negedge clk);
    fa = 1;
    val = v;
    ctl = {13'h1FFF, m};
    repeat (4) @(negedge clk);
  endtask : sm
  task ev(input bit f, output logic [2:0] n);
    @(negedge clk);
    fa = !f;
    tg = !f;
    @(negedge clk);
    tg = 0;
    n = 0;
    repeat (7) @(negedge clk) n += {2'h0, irq};
  endtask : ev
  task t_toggle;
    logic [2:0] n;
    sm(3'h0, 16'h0000);
    ck({1'h0, own, pin}, 3'h1);
    ev(0, n);
    ck(n, 3'h0);
    sm(3'h3, 16'h0000);
    ck({2'h0, pin}, 3'h1);
    ev(0, n);
    ck(n, 3'h1);
    ev(0, n);
    ck(n, 3'h1);
    ck(3'(edges), 3'h3);
    $display("test toggle done");
  endtask : t_toggle
  task t_codes;
    logic [2:0] n;
    pl = 0;
    for (int k = 0; k < 4; k++) begin
      sm(3'h0, 16'h0000);
      sm(CD[k], 16'h0000);
      ck({2'h0, pin}, {2'h0, CD[k] == 3'h2});
      ev(0, n);
      ck(n, {2'h0, k < 2});
      ev(0, n);
      ck(n, {2'h0, k > 1});
    end
    $display("test codes done");
  endtask : t_codes
  task t_pwm;
    logic [2:0] n;
    for (int k = 0; k < 3; k++) begin
      sm(3'h0, 16'h0000);
      sm(k < 2 ? 3'h6 : 3'h7, k > 0 ? 16'h8000 : 16'h0000);
      ck({2'h0, pin}, {2'h0, k > 0});
      ev(1, n);
      ck(n, {2'h0, k == 2});
    end
    ck({1'h0, flt, pin}, 3'h2);
    $display("test pwm done");
  endtask : t_pwm
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1;
    t_toggle;
    t_codes;
    t_pwm;
    print_verdict;
  end
  always @(posedge clk) if (++cyc == 1000) begin
    errors++;
    print_verdict;
  end
endmodule : ocm_mode_logic_tb
